/* File: verilog/tsense_regs.sv */
/*
 * Threshold, scratch and nonvolatile-unlock registers with the conversion
 * cycle sequencer and block averager.
 * Assumes a register port already decoded from the serial link and an ADC
 * that delivers signed samples with a valid strobe.
 */
// Behaviour
// - Averaging field selects 1, 8, 32, 64 samples
// - Cycle field sets period, never below active
// - Active time per averaging, then standby
// - Sixteen-bit read/write upper threshold
// - Upper threshold reloaded from stored copy
// - Lower threshold reloaded, factory value 8000h
// - Locked writes touch working registers only
// - Unlocked writes also program stored copy when not busy
// - Unlock bit 14 mirrors busy flag
// - Busy while programming or reset load
// - Four scratch words, each with stored copy
// - Block average, not running average
// - Mode upper bit never stored
`timescale 1ns/1ns
module tsense_regs
    import tsense_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF,
    parameter int PROG_CYCLES = PROG_CYCLES_DEF,
    parameter int LOAD_CYCLES = LOAD_CYCLES_DEF
) (
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    input wire logic GCALL_RST_I,
    input wire reg_req_t REG_REQ_I,
    output logic [15:0] REG_RDATA_O,
    input wire logic SAMPLE_VALID_I,
    input wire logic [15:0] SAMPLE_I,
    output logic ACTIVE_O,
    output logic [15:0] RESULT_O,
    output logic RESULT_VALID_O,
    output logic [15:0] UPPER_THRESHOLD_O,
    output logic [15:0] LOWER_THRESHOLD_O,
    output logic NV_BUSY_O
);
    logic rst_meta_q;
    logic rst_n_q;
    state_t s_q;
    state_t s_d;
    logic busy;
    logic [15:0] act_t;
    logic [15:0] period_t;
    logic [6:0] avg_n;
    logic last_tick;

    function automatic logic [6:0] avg_count(input logic [1:0] sel);
        case (sel)
            2'h0: avg_count = AVG_N1;
            2'h1: avg_count = AVG_N8;
            2'h2: avg_count = AVG_N32;
            default: avg_count = AVG_N64;
        endcase
    endfunction

    function automatic logic [15:0] active_time(input logic [1:0] sel);
        case (sel)
            2'h0: active_time = T_15M5;
            2'h1: active_time = T_125M;
            2'h2: active_time = T_500M;
            default: active_time = T_1S;
        endcase
    endfunction

    function automatic logic [15:0] cycle_time(input logic [2:0] sel, input logic [15:0] act);
        logic [15:0] t;
        case (sel)
            3'h1: t = T_125M;
            3'h2: t = T_250M;
            3'h3: t = T_500M;
            3'h4: t = T_1S;
            3'h5: t = T_4S;
            3'h6: t = T_8S;
            3'h7: t = T_16S;
            default: t = act;
        endcase
        cycle_time = (t < act) ? act : t;
    endfunction

    function automatic logic [2:0] nv_index(input logic [3:0] addr);
        if (addr == ADDR_CFG) begin
            nv_index = NV_CFG;
        end else if (addr == ADDR_HI) begin
            nv_index = NV_HI;
        end else if (addr == ADDR_LO) begin
            nv_index = NV_LO;
        end else begin
            nv_index = NV_SCR0 + 3'(addr - ADDR_SCR_FIRST);
        end
    endfunction

    function automatic logic is_backed(input logic [3:0] addr);
        is_backed = (addr >= ADDR_CFG && addr <= ADDR_LO)
            || (addr >= ADDR_SCR_FIRST && addr <= ADDR_SCR_LAST);
    endfunction

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    assign busy = s_q.loading || s_q.prog_pend;
    assign avg_n = avg_count(s_q.cfg[CFG_AVG_LO +: 2]);
    assign act_t = active_time(s_q.cfg[CFG_AVG_LO +: 2]);
    assign period_t = cycle_time(s_q.cfg[CFG_CONV_LO +: 3], act_t);
    assign last_tick = s_q.tick == 24'(TICK_CYCLES - 1);

    always_comb begin
        logic [15:0] wd;
        logic [15:0] rd;
        logic [1:0] mode;
        logic [5:0] shift;
        s_d = s_q;
        wd = REG_REQ_I.wdata;
        rd = 16'h0000;
        mode = s_q.cfg[CFG_MOD_LO +: 2];
        shift = 6'h0;
        s_d.result_valid = 1'b0;
        // busy countdown, then reload or program
        if (busy) begin
            if (s_q.busy_cnt != 24'h0) begin
                s_d.busy_cnt = s_q.busy_cnt - 24'h1;
            end else if (s_q.loading) begin
                s_d.loading = 1'b0;
                s_d.cfg = s_q.nv[NV_CFG];
                s_d.hi = s_q.nv[NV_HI];
                s_d.lo = s_q.nv[NV_LO];
                for (int i = 0; i < 4; i++) begin
                    s_d.scr[i] = s_q.nv[int'(NV_SCR0) + i];
                end
            end else begin
                s_d.prog_pend = 1'b0;
                s_d.nv[s_q.prog_idx] = s_q.prog_data;
            end
        end
        if (GCALL_RST_I) begin
            s_d.loading = 1'b1;
            s_d.prog_pend = 1'b0;
            s_d.unlock = 1'b0;
            s_d.busy_cnt = 24'(LOAD_CYCLES - 1);
        end else if (REG_REQ_I.wr) begin
            if (REG_REQ_I.addr == ADDR_CFG) begin
                s_d.cfg = wd & CFG_WMASK;
                if (wd[CFG_MOD_LO +: 2] == MODE_ALIAS) begin
                    s_d.cfg[CFG_MOD_LO +: 2] = MODE_CC;
                end
                s_d.phase = PH_IDLE;
            end else if (REG_REQ_I.addr == ADDR_HI) begin
                s_d.hi = wd;
            end else if (REG_REQ_I.addr == ADDR_LO) begin
                s_d.lo = wd;
            end else if (REG_REQ_I.addr == ADDR_UNLOCK) begin
                // only the unlock bit is writable
                s_d.unlock = wd[UNLOCK_BIT];
            end else if (is_backed(REG_REQ_I.addr)) begin
                s_d.scr[2'(REG_REQ_I.addr - ADDR_SCR_FIRST)] = wd;
            end
            // locked writes stop here; unlocked start programming unless busy
            if (s_q.unlock && is_backed(REG_REQ_I.addr) && !busy) begin
                s_d.prog_pend = 1'b1;
                s_d.prog_idx = nv_index(REG_REQ_I.addr);
                s_d.prog_data = (REG_REQ_I.addr == ADDR_CFG) ? s_d.cfg : wd;
                // mode upper bit kept out of the stored copy
                s_d.prog_data[CFG_MOD_HI_BIT] = (REG_REQ_I.addr == ADDR_CFG)
                    ? 1'b0 : wd[CFG_MOD_HI_BIT];
                s_d.busy_cnt = 24'(PROG_CYCLES - 1);
            end
        end
        if (REG_REQ_I.rd) begin
            if (REG_REQ_I.addr == ADDR_CFG) begin
                rd = s_q.cfg;
                rd[CFG_BUSY_BIT] = busy;
            end else if (REG_REQ_I.addr == ADDR_HI) begin
                rd = s_q.hi;
            end else if (REG_REQ_I.addr == ADDR_LO) begin
                rd = s_q.lo;
            end else if (REG_REQ_I.addr == ADDR_UNLOCK) begin
                rd[UNLOCK_BIT] = s_q.unlock;
                rd[UNLOCK_BUSY_BIT] = busy;
            end else if (is_backed(REG_REQ_I.addr)) begin
                rd = s_q.scr[2'(REG_REQ_I.addr - ADDR_SCR_FIRST)];
            end
            s_d.rdata = rd;
        end
        // Conversion sequencer
        s_d.tick = last_tick ? 24'h0 : s_q.tick + 24'h1;
        case (s_q.phase)
            PH_IDLE: begin
                s_d.tick = 24'h0;
                s_d.elapsed = 16'h0;
                s_d.nsamp = 7'h0;
                s_d.acc = '0;
                if (mode != MODE_SD && !s_q.loading && !(REG_REQ_I.wr
                        && REG_REQ_I.addr == ADDR_CFG)) begin
                    s_d.phase = PH_ACTIVE;
                end
            end
            PH_ACTIVE: begin
                // accumulate a fresh block each cycle
                if (SAMPLE_VALID_I && s_q.nsamp < avg_n) begin
                    s_d.acc = s_q.acc + 22'(signed'(SAMPLE_I));
                    s_d.nsamp = s_q.nsamp + 7'h1;
                end
                if (last_tick) begin
                    s_d.elapsed = s_q.elapsed + 16'h1;
                    // active window ends, publish the average
                    if (s_d.elapsed == act_t) begin
                        for (int k = 0; k < 7; k++) begin
                            if (avg_n[k]) begin
                                shift = 6'(k);
                            end
                        end
                        s_d.result = 16'(s_d.acc >>> shift);
                        s_d.result_valid = 1'b1;
                        s_d.phase = PH_STANDBY;
                        if (mode == MODE_OS) begin
                            s_d.cfg[CFG_MOD_LO +: 2] = MODE_SD;
                            s_d.phase = PH_IDLE;
                        end else if (s_d.elapsed >= period_t) begin
                            s_d.phase = PH_IDLE;
                        end
                    end
                end
            end
            PH_STANDBY: begin
                if (last_tick) begin
                    s_d.elapsed = s_q.elapsed + 16'h1;
                    if (s_d.elapsed >= period_t) begin
                        s_d.phase = PH_IDLE;
                    end
                end
            end
            default: s_d.phase = PH_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            s_q <= '0;
            s_q.phase <= PH_IDLE;
            s_q.cfg <= CFG_FACTORY;
            s_q.hi <= HI_FACTORY;
            s_q.lo <= LO_FACTORY;
            s_q.nv[NV_CFG] <= CFG_FACTORY;
            s_q.nv[NV_HI] <= HI_FACTORY;
            s_q.nv[NV_LO] <= LO_FACTORY;
            for (int i = 0; i < 4; i++) begin
                s_q.scr[i] <= SCR_FACTORY;
                s_q.nv[int'(NV_SCR0) + i] <= SCR_FACTORY;
            end
            s_q.loading <= 1'b1;
            s_q.busy_cnt <= 24'(LOAD_CYCLES - 1);
        end else begin
            s_q <= s_d;
        end
    end

    assign REG_RDATA_O = s_q.rdata;
    assign ACTIVE_O = s_q.phase == PH_ACTIVE;
    assign RESULT_O = s_q.result;
    assign RESULT_VALID_O = s_q.result_valid;
    assign UPPER_THRESHOLD_O = s_q.hi;
    assign LOWER_THRESHOLD_O = s_q.lo;
    assign NV_BUSY_O = busy;

    sequence unlocked_hi_write_s;
        REG_REQ_I.wr && !GCALL_RST_I && REG_REQ_I.addr == ADDR_HI && s_q.unlock && !busy;
    endsequence
    sequence locked_write_s;
        REG_REQ_I.wr && !GCALL_RST_I && !s_q.unlock && !s_q.prog_pend;
    endsequence

    upper_write_a: assert property (@(posedge CLK_I) disable iff (!rst_n_q)
        REG_REQ_I.wr && !GCALL_RST_I && REG_REQ_I.addr == ADDR_HI
        |=> s_q.hi == $past(REG_REQ_I.wdata))
        else $error("upper threshold not written");
    reload_thresh_a: assert property (@(posedge CLK_I) disable iff (!rst_n_q)
        $fell(s_q.loading) && !$past(GCALL_RST_I) |-> s_q.hi == s_q.nv[NV_HI])
        else $error("upper threshold not reloaded");
    reload_lower_a: assert property (@(posedge CLK_I) disable iff (!rst_n_q)
        $fell(s_q.loading) && !$past(GCALL_RST_I) |-> s_q.lo == s_q.nv[NV_LO])
        else $error("lower threshold not reloaded");
    locked_nv_a: assert property (@(posedge CLK_I) disable iff (!rst_n_q)
        locked_write_s |=> !s_q.prog_pend && s_q.nv == $past(s_q.nv))
        else $error("locked write reached stored copy");
    prog_start_a: assert property (@(posedge CLK_I) disable iff (!rst_n_q)
        unlocked_hi_write_s |=> busy [*2] ##0 s_q.prog_idx == NV_HI)
        else $error("unlocked write did not program");
    busy_mirror_a: assert property (@(posedge CLK_I) disable iff (!rst_n_q)
        REG_REQ_I.rd && REG_REQ_I.addr == ADDR_UNLOCK
        |=> REG_RDATA_O[UNLOCK_BUSY_BIT] == $past(busy))
        else $error("busy mirror wrong");
    busy_after_rst_a: assert property (@(posedge CLK_I) disable iff (!rst_n_q)
        $rose(rst_n_q) |-> busy) else $error("no busy during reset load");
    unused_zero_a: assert property (@(posedge CLK_I) disable iff (!rst_n_q)
        REG_REQ_I.rd && REG_REQ_I.addr == ADDR_UNLOCK |=> REG_RDATA_O[13:0] == 14'h0)
        else $error("unlock low bits not zero");
    scratch_write_a: assert property (@(posedge CLK_I) disable iff (!rst_n_q)
        REG_REQ_I.wr && !GCALL_RST_I && REG_REQ_I.addr == ADDR_SCR_LAST
        |=> s_q.scr[3] == $past(REG_REQ_I.wdata))
        else $error("scratch word not written");
    mode_bit_a: assert property (@(posedge CLK_I) disable iff (!rst_n_q)
        !s_q.nv[NV_CFG][CFG_MOD_HI_BIT]) else $error("mode upper bit stored");
    sample_cap_a: assert property (@(posedge CLK_I) disable iff (!rst_n_q)
        s_q.nsamp <= avg_n) else $error("too many samples averaged");
    result_time_a: assert property (@(posedge CLK_I) disable iff (!rst_n_q)
        RESULT_VALID_O |-> $past(s_q.phase) == PH_ACTIVE && s_q.elapsed == act_t)
        else $error("result outside active end");
    period_end_a: assert property (@(posedge CLK_I) disable iff (!rst_n_q)
        $past(s_q.phase) == PH_STANDBY && s_q.phase == PH_IDLE
        && !$past(REG_REQ_I.wr) |-> s_q.elapsed == period_t)
        else $error("standby ended off period");
endmodule

/* File: verilog/tsense_pkg.sv */
/*
 * Constants, register map and state types of the threshold, scratch and
 * conversion-timing register bank.
 * Assumes a single 250 MHz clock and a word-wide register port.
 */
package tsense_pkg;
    localparam int CLK_PERIOD_NS = 4;
    // Timebase tick of 0.5 ms; all cycle times count in ticks
    localparam int TICK_NS = 500000;
    localparam int TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;
    localparam int PROG_TIME_NS = 8000000;
    localparam int PROG_CYCLES_DEF = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int LOAD_TIME_NS = 1500000;
    localparam int LOAD_CYCLES_DEF = LOAD_TIME_NS / CLK_PERIOD_NS;

    localparam logic [3:0] ADDR_CFG = 4'h1;
    localparam logic [3:0] ADDR_HI = 4'h2;
    localparam logic [3:0] ADDR_LO = 4'h3;
    localparam logic [3:0] ADDR_UNLOCK = 4'h4;
    localparam logic [3:0] ADDR_SCR_FIRST = 4'h5;
    localparam logic [3:0] ADDR_SCR_LAST = 4'h8;

    localparam int UNLOCK_BIT = 15;
    localparam int UNLOCK_BUSY_BIT = 14;
    localparam int CFG_BUSY_BIT = 12;
    localparam int CFG_MOD_HI_BIT = 11;
    localparam int CFG_MOD_LO = 10;
    localparam int CFG_CONV_LO = 7;
    localparam int CFG_AVG_LO = 5;
    localparam logic [15:0] CFG_WMASK = 16'h0ffc;
    localparam logic [15:0] CFG_FACTORY = 16'h0220;
    localparam logic [15:0] HI_FACTORY = 16'h6000;
    localparam logic [15:0] LO_FACTORY = 16'h8000;
    localparam logic [15:0] SCR_FACTORY = 16'h0000;
    localparam logic [1:0] MODE_SD = 2'h1;
    localparam logic [1:0] MODE_ALIAS = 2'h2;
    localparam logic [1:0] MODE_OS = 2'h3;
    localparam logic [1:0] MODE_CC = 2'h0;

    localparam int NV_WORDS = 7;
    localparam logic [2:0] NV_CFG = 3'h0;
    localparam logic [2:0] NV_HI = 3'h1;
    localparam logic [2:0] NV_LO = 3'h2;
    localparam logic [2:0] NV_SCR0 = 3'h3;

    // Active times and cycle periods in 0.5 ms ticks
    localparam logic [15:0] T_15M5 = 16'h001f;
    localparam logic [15:0] T_125M = 16'h00fa;
    localparam logic [15:0] T_250M = 16'h01f4;
    localparam logic [15:0] T_500M = 16'h03e8;
    localparam logic [15:0] T_1S = 16'h07d0;
    localparam logic [15:0] T_4S = 16'h1f40;
    localparam logic [15:0] T_8S = 16'h3e80;
    localparam logic [15:0] T_16S = 16'h7d00;
    localparam logic [6:0] AVG_N1 = 7'h01;
    localparam logic [6:0] AVG_N8 = 7'h08;
    localparam logic [6:0] AVG_N32 = 7'h20;
    localparam logic [6:0] AVG_N64 = 7'h40;

    typedef enum logic [1:0] {PH_IDLE, PH_ACTIVE, PH_STANDBY} phase_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [3:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        phase_t phase;
        logic [23:0] tick;
        logic [15:0] elapsed;
        logic [6:0] nsamp;
        logic signed [21:0] acc;
        logic [15:0] result;
        logic result_valid;
        logic [15:0] cfg;
        logic [15:0] hi;
        logic [15:0] lo;
        logic unlock;
        logic [3:0][15:0] scr;
        logic [NV_WORDS-1:0][15:0] nv;
        logic [23:0] busy_cnt;
        logic loading;
        logic prog_pend;
        logic [2:0] prog_idx;
        logic [15:0] prog_data;
        logic [15:0] rdata;
    } state_t;
endpackage

/* File: dv/tsense_host.sv */
/*
 * Register-port host model standing in for the two-wire serial host.
 * Assumes the bank's clock, read data and busy flag; drives at falling edges.
 */
`timescale 1ns/1ns
module tsense_host
    import tsense_pkg::*;
(
    input wire logic clk_i,
    input wire logic [15:0] rdata_i,
    input wire logic busy_i,
    output reg_req_t req_o,
    output logic gcall_o
);
    logic unl_q;

    initial begin
        req_o = '0;
        gcall_o = 1'b0;
        unl_q = 1'b0;
    end

    task automatic wait_idle(output bit ok);
        ok = 1'b0;
        for (int n = 0; n < 100 && !ok; n++) begin
            @(negedge clk_i);
            ok = (busy_i === 1'b0);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bit ok;
        if (unl_q && a >= ADDR_SCR_FIRST && a <= ADDR_SCR_LAST) begin
            return;
        end
        if (unl_q) begin
            wait_idle(ok);
        end
        @(negedge clk_i);
        req_o.wr = 1'b1;
        req_o.addr = a;
        req_o.wdata = d;
        @(negedge clk_i);
        req_o.wr = 1'b0;
        req_o.addr = 4'h0;
        req_o.wdata = ~d;
        if (a == ADDR_UNLOCK) begin
            unl_q = d[UNLOCK_BIT];
        end
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(negedge clk_i);
        req_o.rd = 1'b1;
        req_o.addr = a;
        @(negedge clk_i);
        req_o.rd = 1'b0;
        req_o.addr = 4'h0;
        d = rdata_i;
    endtask

    task automatic gcall();
        @(negedge clk_i);
        gcall_o = 1'b1;
        @(negedge clk_i);
        gcall_o = 1'b0;
        unl_q = 1'b0;
    endtask
endmodule

/* File: dv/tsense_regs_tb.sv */
/*
 * Self-checking bench for the threshold, scratch and timing register bank.
 * Assumes shortened tick, programming and load counts set below.
 */
`timescale 1ns/1ns
module tsense_regs_tb
    import tsense_pkg::*;
;
    localparam int TK = 4;
    localparam int PG = 5;
    localparam int LD = 3;
    logic clk;
    logic arst_n;
    logic gcall;
    reg_req_t req;
    logic [15:0] rdata;
    logic svalid;
    logic [15:0] sample;
    logic active;
    logic [15:0] result;
    logic rvalid;
    logic [15:0] uthr;
    logic [15:0] lthr;
    logic busy;
    int bad_count = 0;
    int checked = 0;

    tsense_regs #(.TICK_CYCLES(TK), .PROG_CYCLES(PG), .LOAD_CYCLES(LD)) dut (
        .CLK_I(clk), .ARST_N_I(arst_n), .GCALL_RST_I(gcall), .REG_REQ_I(req),
        .REG_RDATA_O(rdata), .SAMPLE_VALID_I(svalid), .SAMPLE_I(sample),
        .ACTIVE_O(active), .RESULT_O(result), .RESULT_VALID_O(rvalid),
        .UPPER_THRESHOLD_O(uthr), .LOWER_THRESHOLD_O(lthr), .NV_BUSY_O(busy));
    tsense_host host (.clk_i(clk), .rdata_i(rdata), .busy_i(busy), .req_o(req),
        .gcall_o(gcall));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
            bad_count++;
        end
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] d;
        host.rd(a, d);
        chk(d, exp, "read back");
    endtask

    task automatic t_reset();
        bit ok;
        arst_n = 1'b0;
        repeat (12) @(negedge clk);
        chk({15'h0, busy}, 16'h0001, "busy in reset");
        arst_n = 1'b1;
        host.wait_idle(ok);
        chk({15'h0, ok}, 16'h0001, "load end");
        rdchk(ADDR_HI, HI_FACTORY);
        rdchk(ADDR_LO, LO_FACTORY);
        rdchk(ADDR_UNLOCK, 16'h0000);
    endtask

    task automatic t_locked();
        host.wr(ADDR_HI, 16'h1234);
        host.wr(ADDR_LO, 16'habcd);
        for (int a = 5; a <= 8; a++) begin
            host.wr(a[3:0], 16'h1111 * a[15:0]);
        end
        host.wr(ADDR_CFG, 16'h0a20);
        rdchk(ADDR_CFG, 16'h0220);
        chk(uthr, 16'h1234, "upper out");
        chk(lthr, 16'habcd, "lower out");
        chk({15'h0, busy}, 16'h0000, "busy locked");
        for (int a = 5; a <= 8; a++) begin
            rdchk(a[3:0], 16'h1111 * a[15:0]);
        end
        host.gcall();
        repeat (LD + 4) @(negedge clk);
        rdchk(ADDR_HI, HI_FACTORY);
        rdchk(ADDR_LO, LO_FACTORY);
        rdchk(ADDR_SCR_FIRST, SCR_FACTORY);
    endtask

    task automatic t_unlock();
        bit ok;
        host.wr(ADDR_UNLOCK, 16'hffff);
        rdchk(ADDR_UNLOCK, 16'h8000);
        host.wr(ADDR_HI, 16'h2345);
        rdchk(ADDR_UNLOCK, 16'hc000);
        chk({15'h0, busy}, 16'h0001, "busy programming");
        host.wait_idle(ok);
        chk({15'h0, ok}, 16'h0001, "first program end");
        host.wr(ADDR_CFG, 16'h0c20);
        rdchk(ADDR_CFG, 16'h1c20);
        host.wait_idle(ok);
        chk({15'h0, ok}, 16'h0001, "second program end");
        host.gcall();
        repeat (LD + 4) @(negedge clk);
        rdchk(ADDR_HI, 16'h2345);
        rdchk(ADDR_CFG, 16'h0420);
    endtask

    task automatic t_cycle(input int avg, input int conv, input int n, input int act_t,
        input int per_t);
        int k;
        int act;
        int i;
        bit seen;
        logic [15:0] cfgv;
        cfgv = 16'((conv << 7) | (avg << 5));
        host.wr(ADDR_CFG, cfgv);
        k = 0;
        act = 0;
        i = 0;
        seen = 1'b0;
        while (k < 20000 && !seen) begin
            @(negedge clk);
            k++;
            seen = (rvalid === 1'b1);
            if (active === 1'b1) begin
                act++;
            end
            svalid = (active === 1'b1) && (i < n) && !svalid;
            sample = 16'h0040 + {10'h0, i[0], 5'h0};
            if (svalid) begin
                i++;
            end
        end
        svalid = 1'b0;
        chk({15'h0, seen}, 16'h0001, "result seen");
        chk(result, (n == 1) ? 16'h0040 : 16'h0050, "block mean");
        checked++;
        if (act < act_t * TK - 3 || act > act_t * TK + 3) begin
            $display("FAIL %0t active %0d cycles", $time, act);
            bad_count++;
        end
        k = 0;
        seen = 1'b0;
        while (k < 20000 && !seen) begin
            @(negedge clk);
            k++;
            seen = (rvalid === 1'b1);
        end
        checked++;
        if (k < per_t * TK - 2 || k > per_t * TK + 2) begin
            $display("FAIL %0t period %0d cycles", $time, k);
            bad_count++;
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        arst_n = 1'b0;
        svalid = 1'b0;
        sample = 16'h0000;
        t_reset();
        t_locked();
        t_unlock();
        t_cycle(0, 0, 1, 31, 31);
        t_cycle(0, 1, 1, 31, 250);
        t_cycle(1, 2, 8, 250, 500);
        t_cycle(2, 1, 32, 1000, 1000);
        t_cycle(3, 0, 64, 2000, 2000);
        conclude();
    end

    initial begin
        repeat (50000) @(posedge clk);
        bad_count++;
        conclude();
    end
endmodule
